// *** src/ivr_ctrl.sv ***
// Interrupt vector relocation control with an AXI4-Lite register slave
`timescale 1ns/1ps
module ivr_ctrl
    import ivr_pkg::*;
#(
    parameter int IRQ_COUNT = 17 // Vector table entries, reset included
)
(
    input wire logic aclk,                 // CPU clock, 20 MHz
    input wire logic aresetn,              // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr,   // Write address
    input wire logic [2:0] s_axi_awprot,   // Write protection, unused
    input wire logic s_axi_awvalid,        // Write address valid
    output logic s_axi_awready,            // Write address ready
    input wire logic [31:0] s_axi_wdata,   // Write data
    input wire logic [3:0] s_axi_wstrb,    // Write byte strobes
    input wire logic s_axi_wvalid,         // Write data valid
    output logic s_axi_wready,             // Write data ready
    output logic [1:0] s_axi_bresp,        // Write response
    output logic s_axi_bvalid,             // Write response valid
    input wire logic s_axi_bready,         // Write response ready
    input wire logic [7:0] s_axi_araddr,   // Read address
    input wire logic [2:0] s_axi_arprot,   // Read protection, unused
    input wire logic s_axi_arvalid,        // Read address valid
    output logic s_axi_arready,            // Read address ready
    output logic [31:0] s_axi_rdata,       // Read data
    output logic [1:0] s_axi_rresp,        // Read response
    output logic s_axi_rvalid,             // Read data valid
    input wire logic s_axi_rready,         // Read data ready
    input wire logic [1:0] boot_size_fuses, // Boot section size code
    input wire logic boot_reset_fuse,      // Zero when programmed
    input wire logic app_side_lock_bit,    // Zero when programmed
    input wire logic boot_side_lock_bit,   // Zero when programmed
    input wire logic exec_in_boot,         // CPU executing from boot section
    input wire logic instr_done,           // CPU finished an instruction
    input wire logic [4:0] irq_num,        // Table index of pending vector
    output logic vector_select,            // Vectors in boot section
    output logic ext_irq0_enable,          // External request 0 enable
    output logic ext_irq1_enable,          // External request 1 enable
    output logic ext_irq2_enable,          // External request 2 enable
    output logic irq_block,                // Interrupt dispatch blocked
    output logic [11:0] vector_addr,       // Word address of vector irq_num
    output logic [11:0] reset_addr         // Word address fetched after reset
);
`include "ivr_regs.svh"

    // Index port is five bits; index zero is reset
    if (IRQ_COUNT < 2 || IRQ_COUNT > 32)
    begin
        $error("IRQ_COUNT must lie between 2 and 32");
    end

    ivr_top_regs_type r;      // Current state
    ivr_top_regs_type next_r; // Next state
    ivr_seq_if sif();         // Link to the change sequencer
    logic do_arm;             // Arming write this cycle
    logic do_commit;          // Accepted select write this cycle
    logic next_lock;          // Lock based suppression, next cycle

    // Boot section start word address from the size fuses
    function automatic logic [11:0] boot_start(input logic [1:0] code);
        logic [11:0] a;
        a = `IVR_BOOT_START_00;
        if (code == 2'h1)
        begin
            a = `IVR_BOOT_START_01;
        end
        else if (code == 2'h2)
        begin
            a = `IVR_BOOT_START_10;
        end
        else if (code == 2'h3)
        begin
            a = `IVR_BOOT_START_11;
        end
        // Code zero is the 2K byte section at word C00
        return a;
    endfunction

    // Word-aligned compare of a byte address with a register offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        return addr[7:2] == offs[7:2];
    endfunction

    // Change sequencer: four cycle window and dispatch hold
    ivr_seq u_seq
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif)
    );

    assign sif.arm = do_arm;
    assign sif.commit = do_commit;
    assign sif.instr_done = instr_done;

    // Bus handshakes, register writes and derived outputs
    always_comb
    begin
        next_r = r;
        do_arm = 1'b0;
        do_commit = 1'b0;

        // Address and data may arrive in either order
        if (r.awready && s_axi_awvalid)
        begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid)
        begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end

        // Both halves held: perform the write and answer
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `IVR_RESP_OKAY;
            if (hit(r.awaddr, `IVR_GIC_OFFSET))
            begin
                // All fields sit in byte lane zero
                if (r.wstrb[0])
                begin
                    next_r.gic[`IVR_EXT_IRQ2_ENABLE_BIT] = r.wdata[`IVR_EXT_IRQ2_ENABLE_BIT];
                    next_r.gic[`IVR_EXT_IRQ0_ENABLE_BIT] = r.wdata[`IVR_EXT_IRQ0_ENABLE_BIT];
                    next_r.gic[`IVR_EXT_IRQ1_ENABLE_BIT] = r.wdata[`IVR_EXT_IRQ1_ENABLE_BIT];
                    if (r.wdata[`IVR_VCE_BIT])
                    begin
                        // Writing one opens the change window
                        do_arm = 1'b1;
                    end
                    else if (sif.armed)
                    begin
                        // Select taken only inside the window
                        next_r.gic[`IVR_VSEL_BIT] = r.wdata[`IVR_VSEL_BIT];
                        do_commit = 1'b1;
                    end
                    // Outside the window the select write is dropped
                end
            end
            else if (hit(r.awaddr, `IVR_STATUS_OFFSET))
            begin
                // Status is read-only; writes are accepted and dropped
            end
            else
            begin
                next_r.bresp = `IVR_RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready)
        begin
            next_r.bvalid = 1'b0;
        end
        // One write in flight: ready again once the answer is taken
        next_r.awready = !next_r.aw_got && !next_r.bvalid;
        next_r.wready = !next_r.w_got && !next_r.bvalid;

        // Lock bits suppress dispatch in the section without vectors
        next_lock = 1'b0;
        if (next_r.gic[`IVR_VSEL_BIT] && !app_side_lock_bit && !exec_in_boot)
        begin
            next_lock = 1'b1;
        end
        else if (!next_r.gic[`IVR_VSEL_BIT] && !boot_side_lock_bit && exec_in_boot)
        begin
            next_lock = 1'b1;
        end

        // Read channel: one read at a time, data one edge after address
        if (r.arready && s_axi_arvalid)
        begin
            next_r.rvalid = 1'b1;
            next_r.rdata = 32'h0000_0000;
            next_r.rresp = `IVR_RESP_OKAY;
            if (hit(s_axi_araddr, `IVR_GIC_OFFSET))
            begin
                next_r.rdata[7:0] = r.gic;
                // Enable bit reads back the live window state
                next_r.rdata[`IVR_VCE_BIT] = sif.armed;
            end
            else if (hit(s_axi_araddr, `IVR_STATUS_OFFSET))
            begin
                next_r.rdata[`IVR_ST_BLOCK_BIT] = r.irq_block;
                next_r.rdata[`IVR_ST_ARMED_BIT] = sif.armed;
                next_r.rdata[`IVR_ST_HOLD_BIT] = sif.holding;
                next_r.rdata[`IVR_ST_LOCK_BIT] = next_lock;
                next_r.rdata[`IVR_ST_BOOT_RESET_FUSE_BIT] = !boot_reset_fuse;
                next_r.rdata[`IVR_ST_BASE_LSB +: 12] = boot_start(boot_size_fuses);
            end
            else
            begin
                next_r.rresp = `IVR_RESP_SLVERR;
            end
        end
        if (r.rvalid && s_axi_rready)
        begin
            next_r.rvalid = 1'b0;
        end
        next_r.arready = !next_r.rvalid;

        // Separate block line; the CPU global enable flag is left alone
        next_r.irq_block = sif.next_block || next_lock;

        // Vector fetch address, relocated by the boot start
        if (next_r.gic[`IVR_VSEL_BIT])
        begin
            next_r.vector_addr = boot_start(boot_size_fuses) + {7'h00, irq_num};
        end
        else
        begin
            next_r.vector_addr = {7'h00, irq_num};
        end

        // Reset fetch address follows the boot reset fuse
        if (!boot_reset_fuse)
        begin
            next_r.reset_addr = boot_start(boot_size_fuses);
        end
        else
        begin
            next_r.reset_addr = 12'h000;
        end
    end

    // State register; reset clears every control bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
            r.gic <= `IVR_GIC_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign vector_select = r.gic[`IVR_VSEL_BIT];
    assign ext_irq0_enable = r.gic[`IVR_EXT_IRQ0_ENABLE_BIT];
    assign ext_irq1_enable = r.gic[`IVR_EXT_IRQ1_ENABLE_BIT];
    assign ext_irq2_enable = r.gic[`IVR_EXT_IRQ2_ENABLE_BIT];
    assign irq_block = r.irq_block;
    assign vector_addr = r.vector_addr;
    assign reset_addr = r.reset_addr;
endmodule

// *** src/ivr_pkg.sv ***
// Types of the vector control block
package ivr_pkg;

    // Sequencer states, Gray coded along idle -> armed -> hold
    typedef enum logic [1:0]
    {
        IVR_SEQ_IDLE = 2'b00,
        IVR_SEQ_ARMED = 2'b01,
        IVR_SEQ_HOLD = 2'b11
    } ivr_seq_state_type;

    // Complete state of the change sequencer
    typedef struct packed
    {
        ivr_seq_state_type state;
        logic [2:0] cnt;
    } ivr_seq_regs_type;

    // Complete state of the top-level block
    typedef struct packed
    {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] gic;
        logic irq_block;
        logic [11:0] vector_addr;
        logic [11:0] reset_addr;
    } ivr_top_regs_type;

endpackage

// *** src/ivr_regs.svh ***
// Offsets, fields, reset values and counts of the vector control block
`ifndef IVR_REGS_SVH
`define IVR_REGS_SVH

// Register byte offsets (word aligned)
`define IVR_GIC_OFFSET 8'h00
`define IVR_STATUS_OFFSET 8'h04

// General interrupt control fields
`define IVR_VCE_BIT 0
`define IVR_VSEL_BIT 1
`define IVR_EXT_IRQ2_ENABLE_BIT 5
`define IVR_EXT_IRQ0_ENABLE_BIT 6
`define IVR_EXT_IRQ1_ENABLE_BIT 7
`define IVR_GIC_RESET 8'h00

// Status register fields
`define IVR_ST_BLOCK_BIT 0
`define IVR_ST_ARMED_BIT 1
`define IVR_ST_HOLD_BIT 2
`define IVR_ST_LOCK_BIT 3
`define IVR_ST_BOOT_RESET_FUSE_BIT 4
`define IVR_ST_BASE_LSB 16

// Change window length in clock cycles
`define IVR_CHG_WINDOW 3'h4

// Boot section start word address per boot size fuse code
`define IVR_BOOT_START_00 12'hc00
`define IVR_BOOT_START_01 12'he00
`define IVR_BOOT_START_10 12'hf00
`define IVR_BOOT_START_11 12'hf80

// AXI responses
`define IVR_RESP_OKAY 2'h0
`define IVR_RESP_SLVERR 2'h2

`endif

// *** src/ivr_seq.sv ***
// Timed unlock sequencer for relocating the interrupt vector table
`timescale 1ns/1ps
module ivr_seq
    import ivr_pkg::*;
(
    input wire logic aclk,    // CPU clock
    input wire logic aresetn, // Synchronous reset, active low
    ivr_seq_if.seq sif        // Sequence controls from the register logic
);
`include "ivr_regs.svh"

    ivr_seq_regs_type r;      // Current state
    ivr_seq_regs_type next_r; // Next state

    // Next state of the change window and the post-commit hold
    always_comb
    begin
        next_r = r;
        if (r.cnt != 3'h0)
        begin
            next_r.cnt = r.cnt - 3'h1;
        end
        case (r.state)
            IVR_SEQ_IDLE:
            begin
                if (sif.arm)
                begin
                    next_r.state = IVR_SEQ_ARMED;
                    next_r.cnt = `IVR_CHG_WINDOW;
                end
            end
            IVR_SEQ_ARMED:
            begin
                // Rewriting the enable restarts the window
                if (sif.arm)
                begin
                    next_r.cnt = `IVR_CHG_WINDOW;
                end
                else if (sif.commit)
                begin
                    // Select written: window closes at once
                    next_r.state = IVR_SEQ_HOLD;
                    next_r.cnt = 3'h0;
                end
                else if (r.cnt == 3'h1)
                begin
                    // Four cycles passed unused: close and release
                    next_r.state = IVR_SEQ_IDLE;
                end
            end
            IVR_SEQ_HOLD:
            begin
                // Dispatch stays blocked until the next instruction ends
                if (sif.arm)
                begin
                    next_r.state = IVR_SEQ_ARMED;
                    next_r.cnt = `IVR_CHG_WINDOW;
                end
                else if (sif.instr_done)
                begin
                    next_r.state = IVR_SEQ_IDLE;
                end
            end
            default:
            begin
                next_r.state = IVR_SEQ_IDLE;
                next_r.cnt = 3'h0;
            end
        endcase
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '{state: IVR_SEQ_IDLE, cnt: 3'h0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign sif.armed = (r.state == IVR_SEQ_ARMED);
    assign sif.holding = (r.state == IVR_SEQ_HOLD);
    // Block from the arming edge on
    assign sif.next_block = (next_r.state != IVR_SEQ_IDLE);
endmodule

// *** src/ivr_seq_if.sv ***
// Register logic to change sequencer link
`timescale 1ns/1ps
interface ivr_seq_if;
    logic arm;        // Change enable written to one
    logic commit;     // Select written while armed
    logic instr_done; // CPU completed an instruction
    logic armed;      // Change window open
    logic holding;    // Waiting for the instruction after the commit
    logic next_block; // Next value of the sequence dispatch block

    modport ctrl (output arm, output commit, output instr_done,
                  input armed, input holding, input next_block);
    modport seq (input arm, input commit, input instr_done,
                 output armed, output holding, output next_block);
endinterface

// *** tb/ivr_cpu_model.sv ***
// CPU core model that reports completed instructions
`timescale 1ns/1ps
module ivr_cpu_model
(
    input wire logic aclk, // CPU clock
    input wire logic aresetn, // Reset, active low
    input wire logic run, // Core executing
    input wire logic [1:0] cpi, // Cycles per instruction minus one
    output logic instr_done // One-cycle completion pulse
);
    logic [1:0] cnt; // Cycles into the current instruction

    // A stalled core gives no pulse, so the hold after a commit can be seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            cnt <= 2'h0;
            instr_done <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == cpi) ? 2'h0 : cnt + 2'h1;
            instr_done <= (cnt == cpi);
        end
    end
endmodule

// *** tb/ivr_ctrl_sva.sv ***
// Assertion checker of the vector relocation control block
`timescale 1ns/1ps
`include "ivr_regs.svh"
module ivr_ctrl_sva
#(
    parameter int IRQ_COUNT = 17 // Vector table entries
)
(
    input wire logic aclk, // CPU clock
    input wire logic aresetn, // Reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Address valid
    input wire logic s_axi_awready, // Address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Data valid
    input wire logic s_axi_wready, // Data ready
    input wire logic s_axi_bvalid, // Response valid
    input wire logic [1:0] boot_size_fuses, // Boot size code
    input wire logic boot_reset_fuse, // Boot reset fuse
    input wire logic app_side_lock_bit, // Application lock
    input wire logic boot_side_lock_bit, // Boot lock
    input wire logic exec_in_boot, // Executing in boot
    input wire logic instr_done, // Instruction done
    input wire logic [4:0] irq_num, // Vector index
    input wire logic vector_select, // Vectors in boot
    input wire logic ext_irq0_enable, // Enable 0
    input wire logic ext_irq1_enable, // Enable 1
    input wire logic ext_irq2_enable, // Enable 2
    input wire logic irq_block, // Dispatch blocked
    input wire logic [11:0] vector_addr, // Vector address
    input wire logic [11:0] reset_addr // Reset address
);
    logic [7:0] wa; // Captured write address
    logic [1:0] wd; // Captured select and enable bits
    logic ws; // Captured lane 0 strobe
    logic bv_q; // Response valid one cycle ago
    logic [2:0] wc; // Change window cycles left
    logic hq; // Waiting for the instruction after a commit
    logic [1:0] up; // Cycles since reset release, saturating
    logic ctl_wr; // Control register written this cycle
    logic wr_arm; // Change enable written to one
    logic cmt; // Select written while the window is open
    logic locks_off; // Both lock bits unprogrammed
    assign ctl_wr = s_axi_bvalid && !bv_q && wa == `IVR_GIC_OFFSET && ws;
    assign wr_arm = ctl_wr && wd[0];
    assign cmt = ctl_wr && !wd[0] && wc != 3'h0;
    assign locks_off = app_side_lock_bit && boot_side_lock_bit;

    // Boot section start per size code
    function automatic logic [11:0] boot_start(input logic [1:0] code);
        case (code)
            2'h0: boot_start = `IVR_BOOT_START_00;
            2'h1: boot_start = `IVR_BOOT_START_01;
            2'h2: boot_start = `IVR_BOOT_START_10;
            default: boot_start = `IVR_BOOT_START_11;
        endcase
    endfunction

    // Own tracking of bus writes and the window
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {bv_q, wc, hq, up} <= '0;
        end
        else
        begin
            bv_q <= s_axi_bvalid;
            up <= {up[0], 1'b1};
            if (s_axi_awvalid && s_axi_awready)
                wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                {ws, wd} <= {s_axi_wstrb[0], s_axi_wdata[1:0]};
            wc <= wr_arm ? 3'h4 : (ctl_wr || wc == 3'h0) ? 3'h0 : wc - 3'h1;
            hq <= (cmt || hq) && !instr_done;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RESET_CLEAR: assert property (
        !up[0] |-> !(vector_select | irq_block | ext_irq0_enable | ext_irq1_enable | ext_irq2_enable))
        else $error("Outputs not cleared by reset");
    AST_VECTOR_ADDR: assert property (
        up[1] |-> vector_addr == (vector_select ? boot_start($past(boot_size_fuses)) :
        12'h000) + 12'($past(irq_num))) else $error("Vector address wrong");
    AST_RESET_ADDR: assert property (
        up[1] |-> reset_addr == ($past(boot_reset_fuse) ? 12'h000 : boot_start($past(boot_size_fuses))))
        else $error("Reset address wrong");
    AST_ARM_BLOCK: assert property (wr_arm |-> irq_block [*4])
        else $error("Dispatch not blocked after arming");
    AST_EXPIRE: assert property (
        wr_arm && locks_off ##1 (!ctl_wr && locks_off) [*4] |-> !irq_block)
        else $error("Block outlived the window");
    AST_SELECT_GUARD: assert property (up[0] && $changed(vector_select) |-> cmt)
        else $error("Select changed outside a commit");
    AST_COMMIT_VALUE: assert property (cmt |-> vector_select == wd[1])
        else $error("Commit did not set select");
    AST_HOLD: assert property ((cmt || hq) && !instr_done |=> irq_block)
        else $error("Block dropped before the next instruction");
    AST_RELEASE: assert property (
        (cmt || hq) && instr_done && locks_off && !wr_arm |=> !irq_block)
        else $error("Block kept after the next instruction");
    AST_LOCK_APP: assert property (
        vector_select && !app_side_lock_bit && !exec_in_boot |=> irq_block)
        else $error("No suppression in application code");
    AST_LOCK_BOOT: assert property (
        !vector_select && !boot_side_lock_bit && exec_in_boot |=> irq_block)
        else $error("No suppression in boot code");

    COV_ARM: cover property (wr_arm);
    COV_MOVE_UP: cover property (cmt && wd[1]);
    COV_HOLD_RELEASE: cover property (hq && instr_done);
endmodule

bind ivr_ctrl ivr_ctrl_sva #(.IRQ_COUNT(IRQ_COUNT)) i_ivr_ctrl_sva (.*);

// *** tb/ivr_ctrl_tb_top.sv ***
// Self-checking bench of the vector relocation control block
`timescale 1ns/1ps
`include "ivr_regs.svh"
`define CHK(what, exp, got) \
    begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module ivr_ctrl_tb_top;
    logic aclk = 1'b0; // 20 MHz clock
    logic aresetn; // Reset, active low
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot; // Unused by the block
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, boot_size_fuses, cpi;
    logic boot_reset_fuse, app_side_lock_bit, boot_side_lock_bit, exec_in_boot, instr_done, run;
    logic [4:0] irq_num;
    logic vector_select, ext_irq0_enable, ext_irq1_enable, ext_irq2_enable, irq_block;
    logic [11:0] vector_addr, reset_addr;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0; // Cycle count for the hang limit

    ivr_ctrl i_ivr_ctrl (.*);
    ivr_cpu_model i_ivr_cpu_model (.aclk, .aresetn, .run, .cpi, .instr_done);

    // Free-running clock
    always #25 aclk = ~aclk;

    // Hang limit, far above the roughly 110 cycles the run needs
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Lets n edges pass, then settles
    task automatic look(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad = 1'b0;
        logic dd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            if (!ad && s_axi_awready)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!dd && s_axi_wready)
            begin
                dd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // External enables set, then wiped by a reset in mid-run
    task automatic t_reset_values();
        logic [31:0] d;
        logic [1:0] r;
        wr(`IVR_GIC_OFFSET, 32'he0, r);
        look(1);
        `CHK("ext enables", 3'h7, {ext_irq2_enable, ext_irq1_enable, ext_irq0_enable})
        @(posedge aclk);
        do_reset();
        rd(`IVR_GIC_OFFSET, d, r);
        `CHK("control after reset", 32'h0, d)
    endtask

    // Select written without arming, plus an unmapped read
    task automatic t_locked_sel();
        logic [31:0] d;
        logic [1:0] r;
        wr(`IVR_GIC_OFFSET, 32'h22, r);
        `CHK("write response", `IVR_RESP_OKAY, r)
        rd(`IVR_GIC_OFFSET, d, r);
        `CHK("unarmed select", 32'h20, d)
        rd(8'h08, d, r);
        `CHK("unmapped response", `IVR_RESP_SLVERR, r)
        rd(`IVR_STATUS_OFFSET, d, r);
        `CHK("status", {4'h0, `IVR_BOOT_START_00, 16'h0}, d)
    endtask

    // Arm then commit back to back, the earliest a bus write allows
    task automatic t_move(input logic sel);
        logic [31:0] d;
        logic [1:0] r;
        run <= 1'b0;
        wr(`IVR_GIC_OFFSET, 32'h1, r);
        wr(`IVR_GIC_OFFSET, {30'h0, sel, 1'b0}, r);
        look(3);
        `CHK("select", sel, vector_select)
        `CHK("held block", 1'b1, irq_block)
        @(posedge aclk);
        rd(`IVR_GIC_OFFSET, d, r);
        `CHK("change enable", 1'b0, d[0])
        run <= 1'b1;
        look(6);
        `CHK("block released", 1'b0, irq_block)
        @(posedge aclk);
        run <= 1'b0;
    endtask

    // Every boot size code, boot reset fuse programmed for codes 0 and 2 only
    task automatic t_vectors(input logic sel);
        logic [11:0] base[4] = '{`IVR_BOOT_START_00, `IVR_BOOT_START_01,
            `IVR_BOOT_START_10, `IVR_BOOT_START_11};
        for (int i = 0; i < 4; i++)
        begin
            boot_size_fuses <= 2'(i);
            irq_num <= 5'(i * 5 + 1);
            boot_reset_fuse <= 1'(i % 2);
            look(2);
            `CHK("vector", (sel ? base[i] : 12'h0) + 12'(i * 5 + 1), vector_addr)
            `CHK("reset address", (i % 2) ? 12'h0 : base[i], reset_addr)
            @(posedge aclk);
        end
    endtask

    // Code runs on the side away from the vectors with that side locked
    task automatic t_lock(input logic sel);
        app_side_lock_bit <= !sel;
        boot_side_lock_bit <= sel;
        exec_in_boot <= !sel;
        look(2);
        `CHK("lock suppression", 1'b1, irq_block)
        @(posedge aclk);
        exec_in_boot <= sel;
        look(2);
        `CHK("suppression lifted", 1'b0, irq_block)
        @(posedge aclk);
        app_side_lock_bit <= 1'b1;
        boot_side_lock_bit <= 1'b1;
    endtask

    // Arming left unused: block ends on time, later select is dropped
    task automatic t_expire();
        logic [31:0] d;
        logic [1:0] r;
        wr(`IVR_GIC_OFFSET, 32'h1, r);
        look(2);
        `CHK("block in window", 1'b1, irq_block)
        look(1);
        `CHK("block expired", 1'b0, irq_block)
        @(posedge aclk);
        wr(`IVR_GIC_OFFSET, 32'h2, r);
        rd(`IVR_GIC_OFFSET, d, r);
        `CHK("late select", 32'h0, d)
    endtask

    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        s_axi_wstrb <= 4'hf;
        {aresetn, boot_size_fuses, irq_num, exec_in_boot, run, cpi} <= '0;
        {boot_reset_fuse, app_side_lock_bit, boot_side_lock_bit} <= 3'h7;
        @(posedge aclk);
        do_reset();
        t_reset_values();
        t_locked_sel();
        t_move(1'b1);
        t_vectors(1'b1);
        t_lock(1'b1);
        cpi <= 2'h3;
        t_move(1'b0);
        t_vectors(1'b0);
        t_lock(1'b0);
        t_expire();
        end_of_test();
    end
endmodule
